// >>> design/scs_pkg.sv
// constants and types for the receiver channel status capture block
// What this block does
// - channel status bits 27:24 go to register low nibble; reset value 0001.
// - channel status bits 29:28 go to bits 5:4 as clock accuracy; reset 11.
// - decode max-length bit and three-bit length code into a word length.
// - truncate outgoing audio words to the indicated length, zeroing lower bits.
// - truncation bypass set passes audio bits through unmodified.
// - lock-lost flag is 1 while clock recovery is unlocked, 0 when locked.
// - invalid-data flag follows the validity bit of the recovered sub-frame.
// - link error flag set on preamble, parity or biphase-mark violation.
// - channel status bit 1 is exposed as the audio-status flag.
// - non-PCM flag set on burst sync code detection, held until NONPCM_LIMIT frames pass with no new burst, then 0.
// - every flag readable in a status register and on selectable output pins.
// - registers update, with update indication, only at end of changed block.
// - all-zero flag set after 1024 consecutive all-zero frames.
// - combined non-audio flag is non-PCM OR audio-status.
package scs_pkg;
  localparam logic [7:0]  ADDR_FREQ_ACC   = 8'h10;
  localparam logic [7:0]  ADDR_WL_ORIG    = 8'h11;
  localparam logic [7:0]  ADDR_STATUS     = 8'h12;
  localparam logic [7:0]  RST_FREQ_ACC    = 8'h31;
  localparam logic [7:0]  RST_WL_ORIG     = 8'h01;
  localparam int          CS_LO           = 24;
  localparam int          CS_HI           = 39;
  localparam int          CS_AUDIO_BIT    = 1;
  localparam logic [7:0]  CS_LAST_BIT     = 8'hbf;
  localparam logic [15:0] BURST_PA        = 16'hf872;
  localparam logic [15:0] BURST_PB        = 16'h4e1f;
  localparam logic [4:0]  AUDIO_BITS      = 5'h18;
  localparam logic [4:0]  SHORT_OFFSET    = 5'h04;
  localparam logic [10:0] ZERO_FRAMES     = 11'h400;
  localparam int          NONPCM_TIMEOUT  = 4096;
  localparam int          FLAG_COUNT      = 8;

  typedef struct packed {
    logic [23:0] audio;
    logic        validity;
    logic        cs_bit;
    logic        first_a;
    logic        block_start;
    logic        preamble_err;
    logic        parity_err;
    logic        biphase_err;
  } scs_subframe_t;

  typedef struct packed {
    logic status_block_updated;
    logic all_zero_frames_flag;
    logic non_audio;
    logic non_pcm;
    logic audio_status;
    logic link_error_flag;
    logic invalid_data;
    logic lock_lost;
  } scs_flags_t;

  function automatic logic [4:0] scs_word_len(input logic max_sel, input logic [2:0] code);
    logic [4:0] len;
    len = 5'h00;
    unique case (code)
      3'b001:  len = 5'h14;
      3'b010:  len = 5'h16;
      3'b100:  len = 5'h17;
      3'b101:  len = 5'h18;
      3'b110:  len = 5'h15;
      default: len = 5'h00;
    endcase
    if (!max_sel && len != 5'h00) begin
      len = len - SHORT_OFFSET;
    end
    return len;
  endfunction : scs_word_len
endpackage : scs_pkg

// >>> design/scs_status_capture.sv
// receiver channel status capture, status flags and audio truncation
`timescale 1ns/1ps
module scs_status_capture
  import scs_pkg::*;
#(
  parameter int NUM_PINS     = 8,
  parameter int NONPCM_LIMIT = NONPCM_TIMEOUT
) (
  // clock and reset
  input  wire logic                    CLOCK,
  input  wire logic                    NRST,
  // recovered receiver data
  input  wire scs_subframe_t           SUBFRAME,
  input  wire logic                    SUBFRAME_STB,
  input  wire logic                    PLL_LOCKED,
  // control
  input  wire logic                    TRUNCATION_BYPASS,
  input  wire logic [NUM_PINS*3-1:0]   PIN_SELECT,
  // register read-back port
  input  wire logic [7:0]              REG_ADDR,
  input  wire logic                    REG_RD,
  input  wire logic                    REG_WR,
  input  wire logic [7:0]              REG_WDATA,
  output logic      [7:0]              REG_RDATA,
  // audio data interface
  output logic      [23:0]             AUDIO_OUT,
  output logic                         AUDIO_OUT_VALID,
  // status
  output scs_flags_t                   FLAGS,
  output logic      [NUM_PINS-1:0]     GENERAL_OUTPUT_PIN
);
  logic [7:0]  rx_cs_freq_accuracy;
  logic [7:0]  rx_cs_wordlen_origfreq;
  logic        audio_status;
  logic [CS_HI:0] cs_acc;
  logic [7:0]  bit_idx;
  logic [10:0] zero_cnt;
  logic        a_zero;
  logic        pa_seen;
  logic [12:0] burst_age;

  wire         is_a        = SUBFRAME_STB && SUBFRAME.first_a;
  wire         is_b        = SUBFRAME_STB && !SUBFRAME.first_a;
  wire [7:0]   next_idx    = SUBFRAME.block_start ? 8'h00 : bit_idx + 8'h01;
  wire         last_bit    = is_a && next_idx == CS_LAST_BIT;
  wire [16:0]  captured    = {cs_acc[CS_HI:CS_LO], cs_acc[CS_AUDIO_BIT]};
  wire [16:0]  stored      = {rx_cs_wordlen_origfreq, rx_cs_freq_accuracy, audio_status};
  wire         update      = last_bit && captured != stored;
  wire         cs_read     = REG_RD && (REG_ADDR == ADDR_FREQ_ACC || REG_ADDR == ADDR_WL_ORIG);
  wire [4:0]   word_len    = scs_word_len(rx_cs_wordlen_origfreq[0],
                                          rx_cs_wordlen_origfreq[3:1]);
  wire [23:0]  keep_mask   = (word_len == 5'h00) ? 24'hffffff
                             : 24'hffffff << (AUDIO_BITS - word_len);
  wire [23:0]  next_audio  = TRUNCATION_BYPASS ? SUBFRAME.audio
                             : SUBFRAME.audio & keep_mask;
  wire         any_err     = SUBFRAME.preamble_err || SUBFRAME.parity_err
                             || SUBFRAME.biphase_err;
  wire         burst_hit   = is_b && pa_seen && SUBFRAME.audio[23:8] == BURST_PB;
  wire         non_pcm_end = is_b && burst_age == 13'(NONPCM_LIMIT);
  wire         next_non_pcm = burst_hit || (FLAGS.non_pcm && !non_pcm_end);
  wire         next_audio_status = update ? captured[0] : audio_status;
  wire         frame_zero  = a_zero && SUBFRAME.audio == 24'h000000;
  wire [7:0]   next_rdata  = (REG_ADDR == ADDR_FREQ_ACC) ? rx_cs_freq_accuracy
                             : (REG_ADDR == ADDR_WL_ORIG) ? rx_cs_wordlen_origfreq
                             : (REG_ADDR == ADDR_STATUS) ? FLAGS : 8'h00;

  // channel status capture
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      bit_idx <= 8'h00;
      cs_acc  <= '0;
    end else if (is_a) begin
      bit_idx <= next_idx;
      if (next_idx <= 8'(CS_HI)) begin
        cs_acc[next_idx[5:0]] <= SUBFRAME.cs_bit;
      end
    end
  end

  // read-only capture registers, writes never reach them
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rx_cs_freq_accuracy    <= RST_FREQ_ACC;
      rx_cs_wordlen_origfreq <= RST_WL_ORIG;
      audio_status           <= 1'b0;
    end else if (update) begin
      rx_cs_freq_accuracy    <= captured[8:1];
      rx_cs_wordlen_origfreq <= captured[16:9];
      audio_status           <= captured[0];
    end
  end

  // zero frame and burst sync detection
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      a_zero    <= 1'b0;
      zero_cnt  <= 11'h000;
      pa_seen   <= 1'b0;
      burst_age <= 13'h0000;
    end else begin
      if (is_a) begin
        a_zero  <= SUBFRAME.audio == 24'h000000;
        pa_seen <= SUBFRAME.audio[23:8] == BURST_PA;
      end
      if (is_b) begin
        zero_cnt <= !frame_zero ? 11'h000
                    : (zero_cnt == ZERO_FRAMES) ? zero_cnt : zero_cnt + 11'h001;
        burst_age <= burst_hit ? 13'h0000
                     : (burst_age == 13'(NONPCM_LIMIT)) ? burst_age : burst_age + 13'h0001;
      end
    end
  end

  // status flags
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      FLAGS <= '0;
    end else begin
      FLAGS.lock_lost <= !PLL_LOCKED;
      if (SUBFRAME_STB) begin
        FLAGS.invalid_data    <= SUBFRAME.validity;
        FLAGS.link_error_flag <= any_err;
      end
      FLAGS.audio_status <= next_audio_status;
      FLAGS.non_pcm      <= next_non_pcm;
      FLAGS.non_audio    <= next_non_pcm || next_audio_status;
      FLAGS.all_zero_frames_flag <= zero_cnt == ZERO_FRAMES;
      if (update) begin
        FLAGS.status_block_updated <= 1'b1;
      end else if (cs_read || (last_bit && !update)) begin
        FLAGS.status_block_updated <= FLAGS.status_block_updated && !cs_read;
      end
    end
  end

  // register read-back and audio output
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      REG_RDATA       <= 8'h00;
      AUDIO_OUT       <= 24'h000000;
      AUDIO_OUT_VALID <= 1'b0;
    end else begin
      REG_RDATA       <= REG_RD ? next_rdata : REG_RDATA;
      AUDIO_OUT       <= SUBFRAME_STB ? next_audio : AUDIO_OUT;
      AUDIO_OUT_VALID <= SUBFRAME_STB;
    end
  end

  // selectable output pins
  wire [NUM_PINS-1:0] next_pins;
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    assign next_pins[p] = FLAGS[PIN_SELECT[p*3 +: 3]];
  end
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      GENERAL_OUTPUT_PIN <= '0;
    end else begin
      GENERAL_OUTPUT_PIN <= next_pins;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_update_at_end: assert property (update |=> FLAGS.status_block_updated
    && rx_cs_freq_accuracy == $past(captured[8:1])) else $error("block update missed");
  a_regs_hold_midblock: assert property (!last_bit |=> $stable(rx_cs_freq_accuracy)
    && $stable(rx_cs_wordlen_origfreq)) else $error("status register changed mid block");
  a_lock_lost: assert property (!PLL_LOCKED [*2] |-> FLAGS.lock_lost)
    else $error("lock lost flag low while unlocked");
  a_invalid_flag: assert property (SUBFRAME_STB |=> FLAGS.invalid_data
    == $past(SUBFRAME.validity)) else $error("invalid flag wrong");
  a_link_error: assert property (SUBFRAME_STB && any_err |=> FLAGS.link_error_flag)
    else $error("link error not flagged");
  a_trunc_zero: assert property (SUBFRAME_STB && !TRUNCATION_BYPASS && word_len != 5'h00
    |=> (AUDIO_OUT & ~$past(keep_mask)) == 24'h000000) else $error("low bits kept");
  a_bypass_pass: assert property (SUBFRAME_STB && TRUNCATION_BYPASS
    |=> AUDIO_OUT == $past(SUBFRAME.audio)) else $error("bypass altered audio");
  a_non_audio_or: assert property (FLAGS.non_audio
    == (FLAGS.non_pcm || FLAGS.audio_status)) else $error("non-audio not the OR");
  a_zero_count: assert property (FLAGS.all_zero_frames_flag
    |-> $past(zero_cnt) == ZERO_FRAMES) else $error("zero flag early");
  a_burst_flag: assert property (burst_hit |=> FLAGS.non_pcm)
    else $error("burst sync missed");

  // read-back, pin and flag checks
  a_status_read: assert property (REG_RD && REG_ADDR == ADDR_STATUS
    |=> REG_RDATA == $past(FLAGS))
    else $error("status read-back wrong");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  a_pin_follows: assert property (NRST
    |=> GENERAL_OUTPUT_PIN[0] == $past(FLAGS[PIN_SELECT[2:0]]))
    else $error("output pin not following its flag");
  a_write_ignored: assert property (REG_WR && !last_bit
    |=> $stable(rx_cs_freq_accuracy) && $stable(rx_cs_wordlen_origfreq))
    else $error("host write reached a status register");
  a_flag_holds: assert property (!update && !cs_read
    |=> $stable(FLAGS.status_block_updated))
    else $error("update flag moved without cause");
  a_read_clears: assert property (cs_read && !update
    |=> !FLAGS.status_block_updated)
    else $error("update flag not cleared by read");
  a_status_bit: assert property (update
    |=> FLAGS.audio_status == $past(captured[0]))
    else $error("audio status bit not taken");
  a_lock_clear: assert property (PLL_LOCKED [*2] |-> !FLAGS.lock_lost)
    else $error("lock lost flag high while locked");
  a_link_clear: assert property (SUBFRAME_STB && !any_err
    |=> !FLAGS.link_error_flag)
    else $error("link error flag without error");
  a_valid_idle: assert property (!SUBFRAME_STB |=> !AUDIO_OUT_VALID)
    else $error("audio valid without a sub-frame");
  a_zero_clear: assert property (is_b && !frame_zero
    |-> ##2 !FLAGS.all_zero_frames_flag)
    else $error("zero flag kept after non-zero frame");
  a_nonpcm_timeout: assert property (non_pcm_end && !burst_hit
    |=> !FLAGS.non_pcm)
    else $error("non-PCM flag not released");

  c_block_update: cover property (update ##1 cs_read);
  c_zero_flag: cover property (FLAGS.all_zero_frames_flag);
  c_non_pcm: cover property (FLAGS.non_pcm);
  c_truncated: cover property (SUBFRAME_STB && word_len != 5'h00 && !TRUNCATION_BYPASS);
  c_unlock: cover property (FLAGS.lock_lost);
endmodule : scs_status_capture

// >>> testbench/scs_src_model.sv
// sub-frame source sending 192-frame channel status blocks
`timescale 1ns/1ps
module scs_src_model
  import scs_pkg::*;
(
  // clock
  input  wire logic     CLOCK,
  // recovered sub-frames
  output scs_subframe_t SUBFRAME,
  output logic          SUBFRAME_STB
);
  logic [39:0] cs = '0;
  int          fc = 0;
  initial begin
    SUBFRAME     = '0;
    SUBFRAME_STB = 1'b0;
  end
  task automatic sub(input logic [23:0] au, input logic va, a, input logic [2:0] er);
    @(posedge CLOCK);
    SUBFRAME     <= {au, va, a & (fc < 40) & cs[fc % 40], a, a & (fc == 0), er};
    SUBFRAME_STB <= 1'b1;
    @(posedge CLOCK);
    SUBFRAME_STB <= 1'b0;
    SUBFRAME     <= ~SUBFRAME;
  endtask : sub
  task automatic frame(input logic [23:0] a, b, input logic va, vb, input logic [2:0] eb);
    sub(a, va, 1'b1, 3'b000);
    sub(b, vb, 1'b0, eb);
    fc = (fc == 191) ? 0 : fc + 1;
  endtask : frame
endmodule : scs_src_model

// >>> testbench/testbench.sv
// self-checking bench for the channel status capture block
`timescale 1ns/1ps
module testbench;
  import scs_pkg::*;
  logic          clock = 1'b0, nrst = 1'b0, pll_locked = 1'b1, byp = 1'b0;
  logic          reg_rd = 1'b0, reg_wr = 1'b0, audio_valid, stb;
  logic [7:0]    reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, general_output_pin;
  logic [23:0]   pin_sel = 24'h053977, audio_out;
  logic [15:0]   lfsr = 16'h57a8, prev = 16'h0131;
  logic          prev1 = 1'b0;
  logic [39:0]   cs;
  logic [25:0]   expq[$];
  scs_flags_t    flags;
  scs_subframe_t sub;
  int            err_count = 0, checks_done = 0, wlen = 0, fc = 0;

  always #12.5 clock = ~clock;

  scs_status_capture #(.NUM_PINS(8), .NONPCM_LIMIT(8)) dut (
    .CLOCK(clock), .NRST(nrst), .SUBFRAME(sub), .SUBFRAME_STB(stb),
    .PLL_LOCKED(pll_locked), .TRUNCATION_BYPASS(byp), .PIN_SELECT(pin_sel),
    .REG_ADDR(reg_addr), .REG_RD(reg_rd), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .AUDIO_OUT(audio_out), .AUDIO_OUT_VALID(audio_valid),
    .FLAGS(flags), .GENERAL_OUTPUT_PIN(general_output_pin));
  scs_src_model src (.CLOCK(clock), .SUBFRAME(sub), .SUBFRAME_STB(stb));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic int wl(input logic mx, input logic [2:0] cd);
    int t[8] = '{0, 20, 22, 0, 23, 24, 21, 0};
    return (t[cd] != 0 && !mx) ? t[cd] - 4 : t[cd];
  endfunction : wl
  task automatic chk(input logic [39:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic rd(input logic [7:0] a, ex);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, ex);
  endtask : rd
  task automatic frm(input logic [23:0] a, b, input logic [2:0] eb);
    logic        va, vb;
    logic [23:0] m;
    va = 1'(rnd());
    vb = 1'(rnd());
    m  = (byp || wlen == 0) ? 24'hffffff : 24'hffffff << (24 - wlen);
    if (fc == 191) begin
      a = 24'h0;
      b = 24'h0;
    end
    expq.push_back({a & m, va, 1'b0});
    expq.push_back({b & m, vb, |eb});
    src.frame(a, b, va, vb, eb);
    fc = (fc == 191) ? 0 : fc + 1;
  endtask : frm
  task automatic blk(input logic [39:0] c);
    logic chg;
    chg    = (c[39:24] != prev) || (c[1] != prev1);
    src.cs = c;
    for (int i = 0; i < 192; i++) frm({rnd(), 8'(rnd())}, {rnd(), 8'(rnd())}, 3'(rnd()));
    wlen  = wl(c[32], c[35:33]);
    prev  = c[39:24];
    prev1 = c[1];
    @(negedge clock);
    chk(flags.status_block_updated, chg);
    chk(flags.audio_status, c[1]);
    chk(flags.non_audio, c[1]);
    rd(ADDR_FREQ_ACC, {2'b00, c[29:24]});
    rd(ADDR_WL_ORIG, c[39:32]);
    chk(flags.status_block_updated, 1'b0);
  endtask : blk

  // audio stream watcher
  always @(posedge clock) begin
    if (audio_valid === 1'b1) begin
      if (expq.size() == 0) chk(40'h1, 40'h0);
      else chk({audio_out, flags.invalid_data, flags.link_error_flag}, expq.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd(ADDR_FREQ_ACC, 8'h31);
    rd(ADDR_WL_ORIG, 8'h01);
    @(posedge clock);
    reg_addr  <= ADDR_FREQ_ACC;
    reg_wdata <= 8'h5a;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    rd(ADDR_FREQ_ACC, 8'h31);
    rd(8'h13, 8'h00);
    pll_locked <= 1'b0;
    repeat (3) @(negedge clock);
    chk(flags.lock_lost, 1'b1);
    chk(general_output_pin, 40'h80);
    rd(ADDR_STATUS, 8'h01);
    pll_locked <= 1'b1;
    repeat (3) @(negedge clock);
    chk(flags.lock_lost, 1'b0);
    for (int k = 0; k < 16; k++) begin
      @(posedge clock);
      byp       <= 1'(rnd());
      cs        = 40'({rnd(), rnd(), rnd()});
      cs[35:30] = {k[3:0], 2'b00};
      @(posedge clock);
      blk(cs);
    end
    frm(24'hf87200, 24'h4e1f00, 3'b000);
    @(negedge clock);
    chk(flags.non_pcm, 1'b1);
    chk(flags.non_audio, 1'b1);
    for (int i = 0; i < 1024; i++) begin
      if (i == 1023) begin
        @(negedge clock);
        chk(flags.all_zero_frames_flag, 1'b0);
      end
      frm(24'h0, 24'h0, 3'b000);
    end
    repeat (2) @(negedge clock);
    chk(flags.all_zero_frames_flag, 1'b1);
    chk(flags.non_pcm, 1'b0);
    frm(24'h000100, 24'h0, 3'b000);
    repeat (2) @(negedge clock);
    chk(flags.all_zero_frames_flag, 1'b0);
    for (int i = 0; i < 10 && expq.size() != 0; i++) @(posedge clock);
    chk(40'(expq.size()), 40'h0);
    test_done();
  end
endmodule : testbench
